// ### src/dpio_pkg.sv
// Constants and carrier types of the dual port I/O expander register block
`default_nettype none

package dpio_pkg;

  // Port geometry
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned GRP_W     = 3;

  // Register index = {group, port}; command bytes 0h..Bh
  localparam logic [GRP_W-1:0] GRP_PINS    = 3'h0;
  localparam logic [GRP_W-1:0] GRP_LATCH   = 3'h1;
  localparam logic [GRP_W-1:0] GRP_INVERT  = 3'h2;
  localparam logic [GRP_W-1:0] GRP_DIR     = 3'h3;
  localparam logic [GRP_W-1:0] GRP_CAPTURE = 3'h4;
  localparam logic [GRP_W-1:0] GRP_CONTROL = 3'h5;
  localparam logic [7:0]       CMD_LAST    = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_RESET   = 4'h0;

  // Values after reset
  localparam logic [PORT_W-1:0] RST_LATCH   = 8'h00;
  localparam logic [PORT_W-1:0] RST_INVERT  = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR     = 8'hff;
  localparam logic [PORT_W-1:0] RST_CAPTURE = 8'h00;
  localparam logic [PORT_W-1:0] RST_RDATA   = 8'h00;
  localparam logic              RST_RATE    = 1'b0;

  // Control register field
  localparam int unsigned       RATE_BIT    = 0;
  localparam logic [PORT_W-2:0] CTRL_UNUSED = 7'h00;

  // Scan timing
  localparam int unsigned SYS_CLK_MHZ      = 200;
  localparam int unsigned SCAN_SLOW_MS     = 32;
  localparam int unsigned SCAN_FAST_US     = 200;
  localparam int unsigned SCAN_SLOW_CYCLES = SCAN_SLOW_MS * 1000 * SYS_CLK_MHZ;
  localparam int unsigned SCAN_FAST_CYCLES = SCAN_FAST_US * SYS_CLK_MHZ;
  localparam int unsigned SCAN_CNT_W       = 23;

  // One register access carried from the link domain
  typedef struct packed {
    logic              write;
    logic              mapped;
    logic [IDX_W-1:0]  idx;
    logic [PORT_W-1:0] data;
  } dpio_req_t;

  typedef enum logic {
    LNK_IDLE = 1'b0,
    LNK_BUSY = 1'b1
  } dpio_lnk_state_t;

endpackage

`default_nettype wire

// ### src/dpio_sync.sv
// Two flip-flop synchroniser for levels and toggles
`default_nettype none

module dpio_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ### src/dpio_port_change.sv
// Pin change detector and capture register of one port
`default_nettype none

module dpio_port_change
  import dpio_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [PORT_W-1:0] pins_i,
  input  wire logic [PORT_W-1:0] dir_i,
  input  wire logic              scan_tick_i,
  input  wire logic              read_clear_i,
  output var  logic              irq_o,
  output var  logic [PORT_W-1:0] capture_o
);

  logic [PORT_W-1:0] reference;
  logic              armed;

  // Raw pin levels, never inverted, masked to input pins
  wire [PORT_W-1:0] diff   = (pins_i ^ reference) & dir_i; // RL15 RL17
  wire              change = |diff;
  wire              first  = scan_tick_i && armed && change && !irq_o;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reference <= RST_CAPTURE;
      armed     <= 1'b0;
      irq_o     <= 1'b0;
      capture_o <= RST_CAPTURE;
    end else begin
      if ((read_clear_i && !first) || (scan_tick_i && !armed)) begin
        reference <= pins_i;
        armed     <= 1'b1;
      end
      // A new change beats a clearing read in the same cycle
      if (first) begin
        irq_o <= 1'b1;
      end else if (read_clear_i) begin
        irq_o <= 1'b0;
      end else if (scan_tick_i && armed) begin
        irq_o <= change;
      end
      if (first) begin
        capture_o <= pins_i; // RL8
      end
    end
  end

endmodule

`default_nettype wire

// ### src/dpio_expander.sv
// Register block of the dual port I/O expander with its link handshake
`default_nettype none
// Overview of operation
// RL1 - Port data read returns present pin levels
// RL2 - Port data write loads that port's latch
// RL3 - Latch read returns latch, not pins
// RL4 - Latch write drives outputs; clears at reset
// RL5 - Set invert bit presents input bit inverted
// RL6 - Direction bit one input, zero output
// RL7 - Direction registers reset to all ones
// RL8 - Capture holds pins at interrupt moment
// RL9 - Capture registers read-only, writes discarded
// RL10 - Control holds only rate bit; rest zero
// RL11 - Two independent eight-bit ports, bit per pin
// RL12 - Command byte 0h..Bh selects registers in order
// RL13 - Rate bit selects 32 ms or 200 us scan
// RL14 - Second control address acts on the first
// RL15 - Only input pins raise change interrupts
// RL16 - Output pins driven from latch, inputs released
// RL17 - Inversion only affects port data reads

module dpio_expander
  import dpio_pkg::*;
#(
  parameter int unsigned SCAN_SLOW = SCAN_SLOW_CYCLES,
  parameter int unsigned SCAN_FAST = SCAN_FAST_CYCLES
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              link_clk_i,
  input  wire logic              lnk_cmd_valid_i,
  input  wire logic [7:0]        lnk_cmd_i,
  input  wire logic              lnk_wr_valid_i,
  input  wire logic [PORT_W-1:0] lnk_wdata_i,
  input  wire logic              lnk_rd_req_i,
  output logic                   lnk_busy_o,
  output logic                   lnk_rd_valid_o,
  output logic      [PORT_W-1:0] lnk_rdata_o,
  input  wire logic [PORT_W-1:0] port0_pins_i,
  output logic      [PORT_W-1:0] port0_pins_o,
  output logic      [PORT_W-1:0] port0_pins_oe_o,
  input  wire logic [PORT_W-1:0] port1_pins_i,
  output logic      [PORT_W-1:0] port1_pins_o,
  output logic      [PORT_W-1:0] port1_pins_oe_o,
  output logic                   int_o,
  output logic                   int_oe_o
);

  // ---------------- Link domain ----------------
  dpio_lnk_state_t   lnk_state;
  dpio_lnk_state_t   next_lnk_state;
  logic [IDX_W-1:0]  lnk_ptr;
  logic              lnk_ptr_mapped;
  dpio_req_t         lnk_req;
  dpio_req_t         lnk_req_new;
  logic              lnk_req_tgl;
  logic              lnk_ack_sync;
  logic              lnk_ack_seen;
  logic              lnk_rd_valid;
  logic [PORT_W-1:0] lnk_rdata;

  // ---------------- System domain ----------------
  logic              sys_req_sync;
  logic              sys_req_seen;
  logic              sys_ack_tgl;
  logic [PORT_W-1:0] sys_rdata;
  logic [PORT_W-1:0] latch     [NUM_PORTS];
  logic [PORT_W-1:0] invert    [NUM_PORTS];
  logic [PORT_W-1:0] dir       [NUM_PORTS];
  logic [PORT_W-1:0] capture   [NUM_PORTS];
  logic [PORT_W-1:0] pin_level [NUM_PORTS];
  logic [NUM_PORTS-1:0] irq;
  logic              rate;
  logic [SCAN_CNT_W-1:0] scan_cnt;
  logic              int_drive;
  logic [2*PORT_W-1:0] pins_sync;

  // Link side accepts one command or transfer while idle
  wire lnk_idle       = (lnk_state == LNK_IDLE);
  wire lnk_cmd_take   = lnk_idle && lnk_cmd_valid_i;
  wire lnk_xfer_req   = lnk_wr_valid_i || lnk_rd_req_i;
  wire lnk_xfer_take  = lnk_idle && !lnk_cmd_valid_i && lnk_xfer_req;
  wire lnk_ack_edge   = lnk_ack_sync ^ lnk_ack_seen;
  wire lnk_done       = (lnk_state == LNK_BUSY) && lnk_ack_edge;
  wire lnk_cmd_mapped = (lnk_cmd_i <= CMD_LAST); // RL12
  wire [IDX_W-1:0] lnk_ptr_pair = {lnk_ptr[IDX_W-1:1], ~lnk_ptr[0]};

  assign lnk_req_new = '{
    write:  lnk_wr_valid_i,
    mapped: lnk_ptr_mapped,
    idx:    lnk_ptr,
    data:   lnk_wdata_i
  };

  always_comb begin
    next_lnk_state = lnk_state;
    case (lnk_state)
      LNK_IDLE: begin
        if (lnk_xfer_take) begin
          next_lnk_state = LNK_BUSY;
        end
      end
      LNK_BUSY: begin
        if (lnk_ack_edge) begin
          next_lnk_state = LNK_IDLE;
        end
      end
      default: begin
        next_lnk_state = LNK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_state <= LNK_IDLE;
    end else begin
      lnk_state <= next_lnk_state;
    end
  end

  // Command pointer; each data byte moves to the other register of the pair
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_ptr        <= IDX_RESET;
      lnk_ptr_mapped <= 1'b1;
    end else if (lnk_cmd_take) begin
      lnk_ptr        <= lnk_cmd_i[IDX_W-1:0]; // RL12
      lnk_ptr_mapped <= lnk_cmd_mapped;
    end else if (lnk_xfer_take) begin
      lnk_ptr        <= lnk_ptr_pair;
    end
  end

  // Request word stays stable until the acknowledge returns
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_req     <= '0;
      lnk_req_tgl <= 1'b0;
    end else if (lnk_xfer_take) begin
      lnk_req     <= lnk_req_new;
      lnk_req_tgl <= ~lnk_req_tgl;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_ack_seen <= 1'b0;
      lnk_rd_valid <= 1'b0;
      lnk_rdata    <= RST_RDATA;
    end else begin
      lnk_ack_seen <= lnk_ack_sync;
      lnk_rd_valid <= lnk_done && !lnk_req.write;
      if (lnk_done && !lnk_req.write) begin
        lnk_rdata <= sys_rdata;
      end
    end
  end

  dpio_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .async_i (sys_ack_tgl),
    .sync_o  (lnk_ack_sync)
  );

  assign lnk_busy_o     = !lnk_idle;
  assign lnk_rd_valid_o = lnk_rd_valid;
  assign lnk_rdata_o    = lnk_rdata;

  // ---------------- System domain logic ----------------
  dpio_sync #(.WIDTH(1)) u_req_sync (
    .clk_i   (sys_clk_i),
    .reset_i (reset_i),
    .async_i (lnk_req_tgl),
    .sync_o  (sys_req_sync)
  );

  dpio_sync #(.WIDTH(2*PORT_W)) u_pin_sync (
    .clk_i   (sys_clk_i),
    .reset_i (reset_i),
    .async_i ({port1_pins_i, port0_pins_i}),
    .sync_o  (pins_sync)
  );

  assign pin_level[0] = pins_sync[PORT_W-1:0];
  assign pin_level[1] = pins_sync[2*PORT_W-1:PORT_W];

  // Decode of the request held by the link side
  wire                 sys_req_edge = sys_req_sync ^ sys_req_seen;
  wire [GRP_W-1:0]     sys_grp      = lnk_req.idx[IDX_W-1:1];
  wire                 sys_port     = lnk_req.idx[0];
  wire                 sys_wr       = sys_req_edge && lnk_req.write && lnk_req.mapped;
  wire                 sys_rd       = sys_req_edge && !lnk_req.write && lnk_req.mapped;
  wire [PORT_W-1:0]    sys_wdata    = lnk_req.data;
  wire                 wr_control   = sys_wr && (sys_grp == GRP_CONTROL); // RL14

  // Read selection
  wire [PORT_W-1:0] rd_pins    = pin_level[sys_port] ^ invert[sys_port]; // RL1 RL5 RL17
  wire [PORT_W-1:0] rd_control = {CTRL_UNUSED, rate}; // RL10 RL14
  wire [PORT_W-1:0] rd_mux =
      !lnk_req.mapped                ? RST_RDATA            :
      (sys_grp == GRP_PINS)          ? rd_pins              :
      (sys_grp == GRP_LATCH)         ? latch[sys_port]      : // RL3
      (sys_grp == GRP_INVERT)        ? invert[sys_port]     :
      (sys_grp == GRP_DIR)           ? dir[sys_port]        :
      (sys_grp == GRP_CAPTURE)       ? capture[sys_port]    :
      (sys_grp == GRP_CONTROL)       ? rd_control           :
                                       RST_RDATA;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_req_seen <= 1'b0;
      sys_ack_tgl  <= 1'b0;
      sys_rdata    <= RST_RDATA;
    end else begin
      sys_req_seen <= sys_req_sync;
      if (sys_req_edge) begin
        sys_rdata   <= rd_mux;
        sys_ack_tgl <= ~sys_ack_tgl;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rate <= RST_RATE;
    end else if (wr_control) begin
      rate <= sys_wdata[RATE_BIT]; // RL10 RL14
    end
  end

  // Scan rate: one tick per scan period
  wire [SCAN_CNT_W-1:0] scan_reload =
      rate ? SCAN_CNT_W'(SCAN_FAST - 1) : SCAN_CNT_W'(SCAN_SLOW - 1); // RL13
  wire scan_tick = (scan_cnt == '0);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // First tick waits for the pin synchroniser to settle
      scan_cnt <= SCAN_CNT_W'(SCAN_SLOW - 1);
    end else if (scan_tick || wr_control) begin
      scan_cnt <= scan_reload;
    end else begin
      scan_cnt <= scan_cnt - 1'b1;
    end
  end

  // Per-port registers and change detection
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire sel        = (sys_port == 1'(p)); // RL11
    wire grp_out    = (sys_grp == GRP_PINS) || (sys_grp == GRP_LATCH);
    wire wr_latch   = sys_wr && sel && grp_out; // RL2 RL4
    wire wr_invert  = sys_wr && sel && (sys_grp == GRP_INVERT);
    wire wr_dir     = sys_wr && sel && (sys_grp == GRP_DIR);
    wire grp_clear  = (sys_grp == GRP_PINS) || (sys_grp == GRP_CAPTURE);
    wire read_clear = sys_rd && sel && grp_clear;

    // Capture group has no write enable at all
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        latch[p]  <= RST_LATCH; // RL4
        invert[p] <= RST_INVERT;
        dir[p]    <= RST_DIR; // RL7
      end else begin
        if (wr_latch) begin
          latch[p] <= sys_wdata;
        end
        if (wr_invert) begin
          invert[p] <= sys_wdata;
        end
        if (wr_dir) begin
          dir[p] <= sys_wdata; // RL6
        end
      end
    end // RL9

    dpio_port_change u_change (
      .sys_clk_i    (sys_clk_i),
      .reset_i      (reset_i),
      .pins_i       (pin_level[p]),
      .dir_i        (dir[p]),
      .scan_tick_i  (scan_tick),
      .read_clear_i (read_clear),
      .irq_o        (irq[p]),
      .capture_o    (capture[p])
    );
  end

  // Open-drain interrupt: pulled low while either port is pending
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_drive <= 1'b0;
    end else begin
      int_drive <= |irq; // RL15
    end
  end

  assign int_o    = 1'b0;
  assign int_oe_o = int_drive;

  // Drivers enabled only for output pins
  assign port0_pins_o    = latch[0]; // RL16
  assign port0_pins_oe_o = ~dir[0]; // RL6 RL16
  assign port1_pins_o    = latch[1]; // RL16
  assign port1_pins_oe_o = ~dir[1]; // RL6 RL16

endmodule

`default_nettype wire

// ### verif/dpio_chk.sv
// Port assertions of the expander register block
`default_nettype none
module dpio_chk
  import dpio_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  input wire logic              link_clk_i,
  input wire logic              lnk_cmd_valid_i,
  input wire logic              lnk_wr_valid_i,
  input wire logic              lnk_rd_req_i,
  input wire logic              lnk_busy_o,
  input wire logic              lnk_rd_valid_o,
  input wire logic [PORT_W-1:0] lnk_rdata_o,
  input wire logic [PORT_W-1:0] port0_pins_o,
  input wire logic [PORT_W-1:0] port0_pins_oe_o,
  input wire logic [PORT_W-1:0] port1_pins_o,
  input wire logic [PORT_W-1:0] port1_pins_oe_o,
  input wire logic              int_o,
  input wire logic              int_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  chk_dir_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(reset_i) |-> (port0_pins_oe_o | port1_pins_oe_o) == 8'h00)
    else $error("pins driven after reset");
  chk_latch_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(reset_i) |-> (port0_pins_o | port1_pins_o) == 8'h00)
    else $error("latch not cleared");
  chk_take_xfer: assert property (@(posedge link_clk_i) disable iff (reset_i)
    (lnk_wr_valid_i || lnk_rd_req_i) && !lnk_busy_o && !lnk_cmd_valid_i |=> lnk_busy_o)
    else $error("transfer not taken");
  chk_busy_end: assert property (@(posedge link_clk_i) disable iff (reset_i)
    $rose(lnk_busy_o) |-> ##[1:16] !lnk_busy_o) else $error("busy stuck");
  chk_rd_done: assert property (@(posedge link_clk_i) disable iff (reset_i)
    lnk_rd_valid_o |-> $fell(lnk_busy_o) ##1 !lnk_rd_valid_o)
    else $error("read answer malformed");
  chk_rdata_hold: assert property (@(posedge link_clk_i) disable iff (reset_i)
    !lnk_rd_valid_o |-> $stable(lnk_rdata_o)) else $error("read data moved");
  chk_latch_src: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $changed(port0_pins_o) || $changed(port1_pins_o) |-> lnk_busy_o)
    else $error("latch moved without write");
  chk_dir_src: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $changed(port0_pins_oe_o) || $changed(port1_pins_oe_o) |-> lnk_busy_o)
    else $error("drive moved without write");
  chk_int_drive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(int_oe_o) |-> !int_o && !(&$past(port0_pins_oe_o, 2) && &$past(port1_pins_oe_o, 2)))
    else $error("interrupt raised with no input pin");
  cov_read: cover property (@(posedge link_clk_i) lnk_rd_valid_o);
  cov_irq: cover property (@(posedge sys_clk_i) $rose(int_oe_o));
  cov_dir: cover property (@(posedge sys_clk_i) $changed(port0_pins_oe_o));
endmodule

bind dpio_expander dpio_chk u_chk (
  .sys_clk_i, .reset_i, .link_clk_i, .lnk_cmd_valid_i, .lnk_wr_valid_i, .lnk_rd_req_i,
  .lnk_busy_o, .lnk_rd_valid_o, .lnk_rdata_o, .port0_pins_o, .port0_pins_oe_o,
  .port1_pins_o, .port1_pins_oe_o, .int_o, .int_oe_o
);
`default_nettype wire

// ### verif/dpio_master.sv
// Link master model issuing command bytes and data transfers
`default_nettype none
module dpio_master
  import dpio_pkg::*;
(
  input  wire logic              link_clk_i,
  input  wire logic              busy_i,
  input  wire logic              rd_valid_i,
  input  wire logic [PORT_W-1:0] rdata_i,
  output var  logic              cmd_valid_o,
  output var  logic [7:0]        cmd_o,
  output var  logic              wr_valid_o,
  output var  logic [PORT_W-1:0] wdata_o,
  output var  logic              rd_req_o,
  output var  logic              hang_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = 8'h00;
    wr_valid_o = 1'b0;
    wdata_o = 8'h00;
    rd_req_o = 1'b0;
    hang_o = 1'b0;
  end
  // Released data lines show the inverse of their last value
  task automatic send_cmd(input logic [7:0] c);
    @(negedge link_clk_i);
    cmd_o = c;
    cmd_valid_o = 1'b1;
    @(negedge link_clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~c;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] d, output logic [7:0] q);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge link_clk_i);
    wdata_o = d;
    wr_valid_o = wr;
    rd_req_o = !wr;
    @(negedge link_clk_i);
    wr_valid_o = 1'b0;
    rd_req_o = 1'b0;
    wdata_o = ~d;
    while (!busy_i && n < 4) begin
      @(negedge link_clk_i);
      n++;
    end
    seen = busy_i;
    n = 0;
    while (busy_i && n < 40) begin
      @(negedge link_clk_i);
      n++;
    end
    if (seen !== 1'b1 || busy_i !== 1'b0 || (!wr && rd_valid_i !== 1'b1)) begin
      hang_o = 1'b1;
    end
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the expander register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpio_pkg::*;
  logic              sys_clk_i, link_clk_i, reset_i, hang;
  logic              lnk_cmd_valid_i, lnk_wr_valid_i, lnk_rd_req_i;
  logic              lnk_busy_o, lnk_rd_valid_o, int_o, int_oe_o;
  logic [7:0]        lnk_cmd_i;
  logic [PORT_W-1:0] lnk_wdata_i, lnk_rdata_o, ext0, ext1, got;
  logic [PORT_W-1:0] port0_pins_i, port0_pins_o, port0_pins_oe_o;
  logic [PORT_W-1:0] port1_pins_i, port1_pins_o, port1_pins_oe_o;
  int                error_cnt;
  int                tests_run;
  logic [7:0]        rst_exp [12] = '{8'h5a, 8'hc3, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  assign port0_pins_i = (port0_pins_oe_o & port0_pins_o) | (~port0_pins_oe_o & ext0);
  assign port1_pins_i = (port1_pins_oe_o & port1_pins_o) | (~port1_pins_oe_o & ext1);
  dpio_expander #(.SCAN_SLOW(40), .SCAN_FAST(8)) uut (
    .sys_clk_i, .reset_i, .link_clk_i, .lnk_cmd_valid_i, .lnk_cmd_i, .lnk_wr_valid_i,
    .lnk_wdata_i, .lnk_rd_req_i, .lnk_busy_o, .lnk_rd_valid_o, .lnk_rdata_o,
    .port0_pins_i, .port0_pins_o, .port0_pins_oe_o, .port1_pins_i, .port1_pins_o,
    .port1_pins_oe_o, .int_o, .int_oe_o
  );
  dpio_master u_master (
    .link_clk_i, .busy_i(lnk_busy_o), .rd_valid_i(lnk_rd_valid_o), .rdata_i(lnk_rdata_o),
    .cmd_valid_o(lnk_cmd_valid_i), .cmd_o(lnk_cmd_i), .wr_valid_o(lnk_wr_valid_i),
    .wdata_o(lnk_wdata_i), .rd_req_o(lnk_rd_req_i), .hang_o(hang)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #1.3;
    forever #3 link_clk_i = ~link_clk_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic sel(input logic [7:0] c);
    u_master.send_cmd(c);
  endtask
  task automatic put(input logic [7:0] d);
    u_master.xfer(1'b1, d, got);
  endtask
  task automatic get(input string what, input logic [7:0] exp);
    u_master.xfer(1'b0, 8'h00, got);
    check(what, got, exp);
  endtask
  task automatic end_of_test();
    check("link handshake", {7'h00, hang}, 8'h00);
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #50us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    reset_i = 1'b1;
    ext0 = 8'h5a;
    ext1 = 8'hc3;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge link_clk_i);
    check("drive", port0_pins_oe_o | port1_pins_oe_o, 8'h00);
    for (int k = 0; k < 12; k++) begin
      sel(8'(k));
      get("reset value", rst_exp[k]);
    end
    sel(8'h02);
    put(8'h3c);
    put(8'ha5);
    check("port0 out", port0_pins_o, 8'h3c);
    check("port1 out", port1_pins_o, 8'ha5);
    check("drive0", port0_pins_oe_o, 8'h00);
    sel(8'h03);
    get("latch1", 8'ha5);
    get("latch0", 8'h3c);
    sel(8'h07);
    put(8'h0f);
    put(8'hf0);
    check("drive1", port1_pins_oe_o, 8'hf0);
    check("drive0", port0_pins_oe_o, 8'h0f);
    sel(8'h00);
    get("pins0", 8'h5c);
    sel(8'h01);
    put(8'h77);
    check("port1 out", port1_pins_o, 8'h77);
    sel(8'h04);
    put(8'hff);
    sel(8'h00);
    get("pins0 inverted", 8'ha3);
    check("port0 out", port0_pins_o, 8'h3c);
    sel(8'h08);
    put(8'h55);
    put(8'h66);
    sel(8'h08);
    get("capture0", 8'h00);
    get("capture1", 8'h00);
    sel(8'h0b);
    put(8'hff);
    sel(8'h0a);
    get("control", 8'h01);
    get("control alias", 8'h01);
    sel(8'h0a);
    put(8'hfe);
    sel(8'h0b);
    get("control alias", 8'h00);
    sel(8'h0a);
    put(8'h01);
    sel(8'h00);
    get("pins0", 8'ha3);
    get("pins1", 8'h73);
    sel(8'h02);
    put(8'h3d);
    sel(8'h12);
    put(8'h99);
    get("unmapped read", 8'h00);
    check("port0 out", port0_pins_o, 8'h3d);
    repeat (40) @(negedge sys_clk_i);
    check("irq from output", {7'h00, int_oe_o}, 8'h00);
    ext0 = 8'h4a;
    for (int n = 0; n < 25 && int_oe_o !== 1'b1; n++) begin
      @(negedge sys_clk_i);
    end
    check("irq", {7'h00, int_oe_o}, 8'h01);
    sel(8'h08);
    get("capture0", 8'h4d);
    repeat (3) @(negedge sys_clk_i);
    check("irq cleared", {7'h00, int_oe_o}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
